//--- bus_lanes_defs.svh
// width and field constants for the processor data, parity and address lanes
// assumes inclusion by bare name from the lane modules
`ifndef BUS_LANES_DEFS_SVH
`define BUS_LANES_DEFS_SVH

`define LANE_COUNT      4
`define DATA_WIDTH      32
`define ADDR_WIDTH      30
`define LINE_ADDR_WIDTH 28
`define ADDR_LOW_BITS   2
`define LANES_ALL_OFF   4'hF
`define STATUS_IDLE     1'h1

`endif

//--- bus_lanes_pkg.sv
// types shared by the lane modules
// assumes the defs header is compiled alongside
`default_nettype none
`include "bus_lanes_defs.svh"

package bus_lanes_pkg;

   // ----------------------------------------
   // write-cycle phase
   // ----------------------------------------
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_FIRST = 2'b01,
      PH_DATA  = 2'b10
   } phase_t;

   typedef logic [`LANE_COUNT-1:0] lanes_t;

endpackage

`default_nettype wire

//--- lane_parity.sv
// parity of one byte lane, with enable-qualified mismatch
// assumes data and parity already sampled on clk
`timescale 1ns/1ps
`default_nettype none

module lane_parity (
   input  wire logic [7:0] byteData,
   input  wire logic       parityIn,
   input  wire logic       laneOn,
   output logic            evenParity,
   output logic            mismatch
);

   // ----------------------------------------
   // even parity and lane check
   // ----------------------------------------
   // parity per byte
   assign evenParity = ^byteData;
   assign mismatch   = laneOn & (evenParity != parityIn);

endmodule // lane_parity

`default_nettype wire

//--- cpu_bus_data_parity_lanes.sv
// address, byte-lane enable, data and byte parity lanes of the processor bus
// assumes bus-cycle sequencing, hold logic and bus sizing drive the control inputs on clk
//
// Overview of operation
// - all bus timing taken on rising edge of the single clock clk
// - word address lines plus byte-lane enables locate each access
// - upper address lines also accept line address for cache invalidation
// - address outputs float during bus grant or address hold
// - byte-lane enables active low, floated while bus is granted away
// - enable 3 to 0 qualify bytes 31:24 down to 7:0
// - least significant byte on bits 7:0, most on 31:24
// - write data driven from second clock of the cycle onward
// - one parity bit per byte, same timing as write data
// - sampled parity only affects status, never returned data
// - parity lines active high, driven from second write clock on
// - parity status shown the clock after ready on reads
// - status reflects data and parity sampled two clock ends before the ready clock end, through the two-stage pin synchronisers
// - parity error drives active-low status low
// - only enabled and sized lanes checked; others never error
// - status high except the clock after read data; never floated
`timescale 1ns/1ps
`default_nettype none
`include "bus_lanes_defs.svh"

module cpu_bus_data_parity_lanes (
   input  wire logic                        clk,
   input  wire logic                        srst,
   input  wire logic                        cycleStart,
   input  wire logic                        cycleWrite,
   input  wire logic                        cycleEnd,
   input  wire logic [`ADDR_WIDTH-1:0]      cpuAddress,
   input  wire logic [`LANE_COUNT-1:0]      cpuLaneEnable,
   input  wire logic [`DATA_WIDTH-1:0]      cpuWriteData,
   input  wire logic                        busGranted,
   input  wire logic                        addressHold,
   input  wire logic [`LANE_COUNT-1:0]      sizeLaneMask,
   input  wire logic                        readReady,
   input  wire logic [`ADDR_WIDTH-1:0]      word_address_lines_in,
   output logic      [`ADDR_WIDTH-1:0]      word_address_lines_out,
   output logic                             word_address_lines_oe_n,
   output logic      [`LANE_COUNT-1:0]      byte_lane_enable_n,
   output logic                             byte_lane_enable_oe_n,
   input  wire logic [`DATA_WIDTH-1:0]      data_lines_in,
   output logic      [`DATA_WIDTH-1:0]      data_lines_out,
   output logic                             data_lines_oe_n,
   input  wire logic [`LANE_COUNT-1:0]      byte_parity_lines_in,
   output logic      [`LANE_COUNT-1:0]      byte_parity_lines_out,
   output logic                             byte_parity_lines_oe_n,
   output logic      [`LINE_ADDR_WIDTH-1:0] invalidateLine,
   output logic      [`DATA_WIDTH-1:0]      readData,
   output logic                             readDataValid,
   output logic                             parity_status_n
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [`ADDR_WIDTH-1:0] addrSync1;
   logic [`ADDR_WIDTH-1:0] addrSync2;
   logic [`DATA_WIDTH-1:0] dataSync1;
   logic [`DATA_WIDTH-1:0] dataSync2;
   logic [`LANE_COUNT-1:0] parSync1;
   logic [`LANE_COUNT-1:0] parSync2;

   always_ff @(posedge clk) begin
      addrSync1 <= word_address_lines_in;
      addrSync2 <= addrSync1;
      dataSync1 <= data_lines_in;
      dataSync2 <= dataSync1;
      parSync1  <= byte_parity_lines_in;
      parSync2  <= parSync1;
   end

   // ----------------------------------------
   // write phase tracking
   // ----------------------------------------
   bus_lanes_pkg::phase_t phase;
   bus_lanes_pkg::phase_t next_phase;
   logic                  floatAddr;
   logic                  writeDrive;

   always_comb begin
      next_phase = phase;
      unique case (phase)
         bus_lanes_pkg::PH_IDLE: begin
            if (cycleStart && cycleWrite && !busGranted) begin
               next_phase = bus_lanes_pkg::PH_FIRST;
            end
         end
         bus_lanes_pkg::PH_FIRST: begin
            next_phase = (cycleEnd || busGranted) ? bus_lanes_pkg::PH_IDLE
                                                  : bus_lanes_pkg::PH_DATA;
         end
         bus_lanes_pkg::PH_DATA: begin
            if (cycleEnd || busGranted) begin
               next_phase = bus_lanes_pkg::PH_IDLE;
            end
         end
         default: next_phase = bus_lanes_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         phase <= bus_lanes_pkg::PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   assign floatAddr  = busGranted | addressHold;
   assign writeDrive = (next_phase != bus_lanes_pkg::PH_IDLE) &&
                       !(next_phase == bus_lanes_pkg::PH_FIRST);

   // ----------------------------------------
   // address and lane enable outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         word_address_lines_out  <= '0;
         word_address_lines_oe_n <= 1'h1;
         byte_lane_enable_n      <= `LANES_ALL_OFF;
         byte_lane_enable_oe_n   <= 1'h1;
      end else begin
         word_address_lines_out  <= cpuAddress;
         word_address_lines_oe_n <= floatAddr;
         byte_lane_enable_n      <= ~cpuLaneEnable;
         byte_lane_enable_oe_n   <= busGranted;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         invalidateLine <= '0;
      end else if (addressHold || busGranted) begin
         invalidateLine <= addrSync2[`ADDR_WIDTH-1:`ADDR_LOW_BITS];
      end
   end

   // ----------------------------------------
   // per-lane parity
   // ----------------------------------------
   bus_lanes_pkg::lanes_t wrParity;
   bus_lanes_pkg::lanes_t laneErr;
   bus_lanes_pkg::lanes_t laneOn;
   logic                  anyErr;

   assign laneOn = cpuLaneEnable & sizeLaneMask;

   genvar g;
   generate
      for (g = 0; g < `LANE_COUNT; g++) begin : gLane
         lane_parity wrLane (
            .byteData   (cpuWriteData[8*g+7:8*g]),
            .parityIn   (1'h0),
            .laneOn     (1'h0),
            .evenParity (wrParity[g]),
            .mismatch   ()
         );
         lane_parity rdLane (
            .byteData   (dataSync2[8*g+7:8*g]),
            .parityIn   (parSync2[g]),
            .laneOn     (laneOn[g]),
            .evenParity (),
            .mismatch   (laneErr[g])
         );
      end
   endgenerate

   assign anyErr = |laneErr;

   // ----------------------------------------
   // reference parity for checks
   // ----------------------------------------
   bus_lanes_pkg::lanes_t refRdParity;
   bus_lanes_pkg::lanes_t refRdBad;

   assign refRdParity = {^dataSync2[31:24], ^dataSync2[23:16],
                         ^dataSync2[15:8], ^dataSync2[7:0]};
   assign refRdBad    = (refRdParity ^ parSync2) & cpuLaneEnable & sizeLaneMask;

   // ----------------------------------------
   // write data and parity drive
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         data_lines_out         <= '0;
         data_lines_oe_n        <= 1'h1;
         byte_parity_lines_out  <= '0;
         byte_parity_lines_oe_n <= 1'h1;
      end else begin
         data_lines_out         <= cpuWriteData;
         data_lines_oe_n        <= !writeDrive;
         byte_parity_lines_out  <= wrParity;
         byte_parity_lines_oe_n <= !writeDrive;
      end
   end

   // ----------------------------------------
   // read return and parity status
   // ----------------------------------------
   logic readTaken;
   logic next_status;

   assign readTaken   = readReady & ~cycleWrite;
   assign next_status = readTaken ? !anyErr : `STATUS_IDLE;

   always_ff @(posedge clk) begin
      if (srst) begin
         readData        <= '0;
         readDataValid   <= 1'h0;
         parity_status_n <= `STATUS_IDLE;
      end else begin
         readData        <= dataSync2;
         readDataValid   <= readTaken;
         parity_status_n <= next_status;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // idle high
   AST_STATUS_IDLE: assert property (@(posedge clk) disable iff (srst)
      !$past(readTaken) |-> parity_status_n)
      else $error("parity status low outside read slot");
   AST_STATUS_ERR: assert property (@(posedge clk) disable iff (srst)
      readTaken |=> (parity_status_n == !$past(anyErr)))
      else $error("parity status does not match sampled lanes");
   AST_LANE_MASK: assert property (@(posedge clk) disable iff (srst)
      readTaken && (laneOn == 4'h0) |=> parity_status_n)
      else $error("disabled lanes flagged error");
   AST_WR_FIRST: assert property (@(posedge clk) disable iff (srst)
      phase == bus_lanes_pkg::PH_IDLE && next_phase == bus_lanes_pkg::PH_FIRST
      |=> data_lines_oe_n)
      else $error("write data driven in first clock");
   AST_WR_DRIVE: assert property (@(posedge clk) disable iff (srst)
      phase == bus_lanes_pkg::PH_FIRST && next_phase == bus_lanes_pkg::PH_DATA
      |=> !data_lines_oe_n && !byte_parity_lines_oe_n)
      else $error("write data or parity not driven in second clock");
   AST_WR_PARITY: assert property (@(posedge clk) disable iff (srst)
      !data_lines_oe_n |-> (byte_parity_lines_out[0] == ^data_lines_out[7:0]) &&
                         (byte_parity_lines_out[1] == ^data_lines_out[15:8]) &&
                         (byte_parity_lines_out[2] == ^data_lines_out[23:16]) &&
                         (byte_parity_lines_out[3] == ^data_lines_out[31:24]))
      else $error("write parity wrong");
   AST_ADDR_FLOAT: assert property (@(posedge clk) disable iff (srst)
      floatAddr |=> word_address_lines_oe_n)
      else $error("address driven during hold");
   AST_BE_FLOAT: assert property (@(posedge clk) disable iff (srst)
      busGranted |=> byte_lane_enable_oe_n && byte_lane_enable_n == ~$past(cpuLaneEnable))
      else $error("lane enables driven during grant");
   AST_RD_DATA: assert property (@(posedge clk) disable iff (srst)
      readTaken |=> readData == $past(dataSync2))
      else $error("read data altered");
   AST_STATUS_OK: assert property (@(posedge clk) disable iff (srst)
      readTaken && (refRdBad == 4'h0) |=> parity_status_n)
      else $error("parity status low with clean enabled lanes");
   AST_STATUS_BAD: assert property (@(posedge clk) disable iff (srst)
      readTaken && (refRdBad != 4'h0) |=> !parity_status_n)
      else $error("parity status high with bad enabled lane");
   AST_RD_VALID: assert property (@(posedge clk) disable iff (srst)
      readTaken |=> readDataValid)
      else $error("read valid missing after ready");
   AST_VALID_IDLE: assert property (@(posedge clk) disable iff (srst)
      !readTaken |=> !readDataValid)
      else $error("read valid outside read slot");
   AST_STATUS_WRITE: assert property (@(posedge clk) disable iff (srst)
      cycleWrite |=> parity_status_n)
      else $error("parity status low after write clock");
   AST_PAR_OE: assert property (@(posedge clk) disable iff (srst)
      data_lines_oe_n == byte_parity_lines_oe_n)
      else $error("parity drive differs from data drive");
   AST_WR_DATA: assert property (@(posedge clk) disable iff (srst)
      writeDrive |=> data_lines_out == $past(cpuWriteData))
      else $error("write data differs from core data");
   AST_WR_END: assert property (@(posedge clk) disable iff (srst)
      phase == bus_lanes_pkg::PH_DATA && cycleEnd |=> data_lines_oe_n)
      else $error("write data driven after cycle end");
   AST_GRANT_WR: assert property (@(posedge clk) disable iff (srst)
      busGranted |=> data_lines_oe_n && byte_parity_lines_oe_n)
      else $error("write lanes driven while bus granted away");
   AST_ADDR_DRIVE: assert property (@(posedge clk) disable iff (srst)
      !floatAddr |=> !word_address_lines_oe_n)
      else $error("address floated without grant or hold");
   AST_BE_DRIVE: assert property (@(posedge clk) disable iff (srst)
      !busGranted |=> !byte_lane_enable_oe_n)
      else $error("lane enables floated without grant");
   AST_INV_LINE: assert property (@(posedge clk) disable iff (srst)
      addressHold |=> invalidateLine == $past(addrSync2[`ADDR_WIDTH-1:`ADDR_LOW_BITS]))
      else $error("invalidation line address not captured");
   AST_ADDR_OUT: assert property (@(posedge clk) disable iff (srst)
      cycleStart |=> word_address_lines_out == $past(cpuAddress))
      else $error("address lines differ from core address");

   COV_RD_ERR: cover property (@(posedge clk) disable iff (srst)
      readTaken ##1 !parity_status_n);
   COV_RD_OK: cover property (@(posedge clk) disable iff (srst)
      readTaken ##1 parity_status_n);
   COV_WRITE: cover property (@(posedge clk) disable iff (srst)
      phase == bus_lanes_pkg::PH_FIRST ##1 phase == bus_lanes_pkg::PH_DATA);
   COV_HOLD: cover property (@(posedge clk) disable iff (srst) addressHold);
   COV_GRANT: cover property (@(posedge clk) disable iff (srst)
      busGranted ##1 byte_lane_enable_oe_n);

endmodule // cpu_bus_data_parity_lanes

`default_nettype wire

//--- bus_memory_model.sv
// far-side model: memory and bus controller returning read data and byte parity
// assumes the bench sets drive, word and flipLanes at the falling edge of clk
`timescale 1ns/1ps
`default_nettype none

module bus_memory_model (
   input  wire logic        clk,
   input  wire logic        drive,
   input  wire logic [31:0] word,
   input  wire logic [3:0]  flipLanes,
   output logic      [31:0] dataPins,
   output logic      [3:0]  parityPins
);
   logic [31:0] lastWord = 32'h0;
   logic [3:0]  evenBits;

   // ----------------------------------------
   // released lines
   // ----------------------------------------
   // rising edge capture
   always @(posedge clk) begin
      if (drive) begin
         lastWord <= word;
      end
   end

   // ----------------------------------------
   // returned lanes
   // ----------------------------------------
   // all lanes returned
   always_comb begin
      for (int g = 0; g < 4; g++) begin
         evenBits[g] = ^word[8*g +: 8];
      end
   end
   assign dataPins = drive ? word : ~lastWord;
   // even parity, read timing; pull-up when released
   assign parityPins = drive ? (evenBits ^ flipLanes) : 4'hF;
endmodule // bus_memory_model
`default_nettype wire

//--- cpu_bus_data_parity_lanes_tb_top.sv
// self-checking bench for the address, lane, data and parity block
// assumes the far-side model file and the defs header are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "bus_lanes_defs.svh"

module cpu_bus_data_parity_lanes_tb_top;
   logic        clk = 1'b0, srst = 1'b1, cStart = 1'b0, cWrite = 1'b0, cEnd = 1'b0;
   logic        grant = 1'b0, hold = 1'b0, ready = 1'b0, mDrive = 1'b0;
   logic [29:0] cAddr = 30'h0, tbAddr = 30'h0, aPin, aOut;
   logic [3:0]  cLane = 4'hF, sMask = 4'hF, mFlip = 4'h0, pPin, mPar, pOut, laneN;
   logic [31:0] wData = 32'h0, mWord = 32'h0, dPin, mData, dOut, rData;
   logic        aOe, laneOe, dOe, pOe, rValid, pStat;
   logic [27:0] invLine;
   int          nFail = 0, checks = 0, cycles = 0;

   always #4 clk = ~clk;
   assign aPin = !aOe ? aOut : tbAddr;
   assign dPin = !dOe ? dOut : mData;
   assign pPin = !pOe ? pOut : mPar;

   bus_memory_model MEM (.clk(clk), .drive(mDrive), .word(mWord), .flipLanes(mFlip),
      .dataPins(mData), .parityPins(mPar));

   cpu_bus_data_parity_lanes DUT (.clk(clk), .srst(srst), .cycleStart(cStart),
      .cycleWrite(cWrite), .cycleEnd(cEnd), .cpuAddress(cAddr), .cpuLaneEnable(cLane),
      .cpuWriteData(wData), .busGranted(grant), .addressHold(hold), .sizeLaneMask(sMask),
      .readReady(ready), .word_address_lines_in(aPin), .word_address_lines_out(aOut),
      .word_address_lines_oe_n(aOe), .byte_lane_enable_n(laneN),
      .byte_lane_enable_oe_n(laneOe), .data_lines_in(dPin), .data_lines_out(dOut),
      .data_lines_oe_n(dOe), .byte_parity_lines_in(pPin), .byte_parity_lines_out(pOut),
      .byte_parity_lines_oe_n(pOe), .invalidateLine(invLine), .readData(rData),
      .readDataValid(rValid), .parity_status_n(pStat));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [3:0] evenPar(input logic [31:0] w);
      for (int g = 0; g < 4; g++) begin
         evenPar[g] = ^w[8*g +: 8];
      end
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         nFail++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic read_pair(input logic [31:0] w0, input logic [3:0] f0, input logic [31:0] w1,
                            input logic [3:0] f1, input logic s0, input logic s1);
      @(negedge clk); mDrive = 1'b1; mWord = w0; mFlip = f0;
      @(negedge clk); mWord = w1; mFlip = f1;
      @(negedge clk); ready = 1'b1;
      @(negedge clk);
      check(pStat, s0);
      check(rValid, 1'b1);
      check(rData, w0);
      @(negedge clk); ready = 1'b0;
      check(pStat, s1);
      check(rData, w1);
      @(negedge clk); mDrive = 1'b0;
      check(pStat, 1'b1);
      check(rValid, 1'b0);
   endtask

   task automatic test_reads();
      for (int g = 0; g < 4; g++) begin
         read_pair(32'h8040_2010 << g, 4'h1 << g, 32'hA5C3_0F96, 4'h0, 1'b0, 1'b1);
      end
      cLane = 4'h7;
      read_pair(32'h1234_5678, 4'h8, 32'h0000_0001, 4'h1, 1'b1, 1'b0);
      cLane = 4'hF; sMask = 4'h3;
      read_pair(32'hFFFF_FF00, 4'h4, 32'h00FF_0000, 4'hC, 1'b1, 1'b1);
      sMask = 4'hF;
      cLane = 4'h0;
      read_pair(32'h5A5A_5A5A, 4'hF, 32'h0000_0000, 4'hF, 1'b1, 1'b1);
      cLane = 4'hF;
      $display("test reads done");
   endtask

   task automatic test_write();
      @(negedge clk); cStart = 1'b1; cWrite = 1'b1; wData = 32'hC0DE_1B7E; cLane = 4'hA;
      cAddr = 30'h2ABC_1234;
      @(negedge clk); cStart = 1'b0;
      check(dOe, 1'b1);
      @(negedge clk); cEnd = 1'b1;
      check(dOe, 1'b0);
      check(dOut, wData);
      check(pOe, 1'b0);
      check(pOut, evenPar(wData));
      check(laneN, 4'h5);
      check(aOut, cAddr);
      check(aOe, 1'b0);
      @(negedge clk); cEnd = 1'b0; cWrite = 1'b0; cLane = 4'hF;
      @(negedge clk);
      check(dOe, 1'b1);
      check(pOe, 1'b1);
      $display("test write done");
   endtask

   task automatic test_hold();
      @(negedge clk); grant = 1'b1;
      @(negedge clk); cStart = 1'b1; cWrite = 1'b1;
      @(negedge clk); cStart = 1'b0;
      repeat (2) @(negedge clk);
      check(dOe, 1'b1);
      check(aOe, 1'b1);
      check(laneOe, 1'b1);
      cEnd = 1'b1; grant = 1'b0; hold = 1'b1; tbAddr = 30'h3F0F_5A5C;
      @(negedge clk); cEnd = 1'b0; cWrite = 1'b0;
      repeat (5) @(negedge clk);
      check(aOe, 1'b1);
      check(invLine, tbAddr[29:2]);
      hold = 1'b0;
      $display("test hold done");
   endtask

   initial begin
      repeat (6) @(negedge clk);
      check(aOe & laneOe & dOe & pOe, 1'b1);
      check(laneN, 4'hF);
      check(pStat, 1'b1);
      srst = 1'b0;
      test_reads();
      test_write();
      test_hold();
      give_verdict();
   end
endmodule // cpu_bus_data_parity_lanes_tb_top
`default_nettype wire
